/* verilog/asspi_regs.vh */
`ifndef ASSPI_REGS_VH
`define ASSPI_REGS_VH
`define ASSPI_CMD_READ 3'h2
`define ASSPI_CMD_WRITE 3'h4
`define ASSPI_CMD_MSB 15
`define ASSPI_CMD_LSB 13
`define ASSPI_ADDR_MSB 12
`define ASSPI_ADDR_LSB 8
`define ASSPI_DATA_MSB 7
`define ASSPI_DATA_LSB 0
`define ASSPI_FLAG_REG 5'h1B
`define ASSPI_FLAG_HIGH_BIT 7
`define ASSPI_FLAG_LOW_BIT 6
`define ASSPI_FRAME_BITS 16
`define ASSPI_PARITY_BIT 17
`define ASSPI_REFRESH_NS 1000
`define ASSPI_CLK_NS 8
`define ASSPI_REFRESH_CYC (`ASSPI_REFRESH_NS / `ASSPI_CLK_NS)
`define ASSPI_REG_RESET 8'h00
`endif

/* verilog/asspi_sync.v */
`timescale 1ns/1ns
`default_nettype none
// two-stage synchroniser for pin inputs
module asspi_sync #(
  parameter W = 3,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // async in, synced out
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      // each bit resets to its pin's idle level, so no false edge follows reset
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end
  assign q = sync_ff;
endmodule
`default_nettype wire

/* verilog/asspi_slave.v */
// Contract
// [R1] modes 0 and 3 detected automatically
// [R2] master keeps serial clock at 25MHz; slave needs 4 clocks per level, bench runs 64 ns periods
// [R3] commands on mosi, 16-bit frames
// [R4] sample rising, shift falling, msb first
// [R5] parity bit on seventeenth clock
// [R6] parity makes total ones even
// [R7] angle buffer reloads every microsecond
// [R8] chip select low freezes output buffer
// [R9] angle read: mosi zero, 16 clocks
// [R10] short angles padded with low zeros
// [R11] master may shorten angle reads
// [R12] fast reads repeat same angle value
// [R13] read angle, read register, write register
// [R14] read frame: command 010, address
// [R15] read frame low byte is zero
// [R16] second frame returns register upper byte
// [R17] write 100, address, value; echo next
// [R18] 150 ns gap between angle reads
// [R19] 750 ns gap around register reads
// [R20] master waits 20 ms after write; bench waits only the 800 ns idle gap
// [R21] field flags in register 27 bits 7,6
// [R22] first read frame returns angle word
`timescale 1ns/1ns
`default_nettype none
`include "asspi_regs.vh"
module asspi_slave #(
  parameter ANGLE_BITS = 12,
  parameter REFRESH_CYC = `ASSPI_REFRESH_CYC,
  parameter NREGS = 32
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // spi pins
  input wire cs_n,
  input wire sclk,
  input wire mosi,
  output reg miso_ff,
  output reg miso_oe_ff,
  // sensor side
  input wire [ANGLE_BITS-1:0] angle_in,
  input wire field_high_flag,
  input wire field_low_flag,
  // register write strobe toward non-volatile store
  output reg wr_pulse_ff,
  output reg [4:0] wr_addr_ff,
  output reg [7:0] wr_data_ff
);
  localparam ST_IDLE = 2'b01;
  localparam ST_FRAME = 2'b10;
  // counter is 7 bits wide; refresh periods above 128 clocks need it widened
  localparam [6:0] REFRESH_LAST = REFRESH_CYC[6:0] - 7'h01;

  wire [2:0] pins_s;
  wire cs_n_s;
  wire sclk_s;
  wire mosi_s;
  // cs_n resets to its idle high level, so no false select follows reset
  asspi_sync #(
    .W(3),
    .RST_VAL(3'h4)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d({cs_n, sclk, mosi}),
    .q(pins_s)
  );
  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign mosi_s = pins_s[0];

  // [R6] xor gives even ones
  function parity_even;
    input [15:0] w;
    begin
      parity_even = ^w;
    end
  endfunction

  reg [1:0] state_ff;
  reg sclk_d_ff;
  reg cs_d_ff;
  reg [6:0] ref_cnt_ff;
  reg [15:0] angle_buf_ff;
  reg [15:0] shift_ff;
  reg [15:0] rx_ff;
  reg [15:0] tx_word_ff;
  reg [4:0] bit_cnt_ff;
  reg pend_ff;
  reg [15:0] pend_word_ff;
  // register file; bits 7:6 of register 27 are never read from it
  reg [7:0] regs_ff [0:NREGS-1];

  wire sclk_rise = sclk_s & ~sclk_d_ff;
  wire sclk_fall = ~sclk_s & sclk_d_ff;
  wire cs_fall = ~cs_n_s & cs_d_ff;
  wire cs_rise = cs_n_s & ~cs_d_ff;
  // [R10] low zeros padded
  wire [15:0] angle_pad = {angle_in, {(16 - ANGLE_BITS){1'b0}}};
  wire [15:0] rx_full = {rx_ff[14:0], mosi_s};
  wire [2:0] rx_cmd = rx_full[`ASSPI_CMD_MSB:`ASSPI_CMD_LSB];
  wire [4:0] rx_addr = rx_full[`ASSPI_ADDR_MSB:`ASSPI_ADDR_LSB];
  wire [7:0] rx_data = rx_full[`ASSPI_DATA_MSB:`ASSPI_DATA_LSB];
  // [R21] live field flags
  wire [7:0] rd_val = (rx_addr == `ASSPI_FLAG_REG) ?
    {field_high_flag, field_low_flag, regs_ff[rx_addr][5:0]} : regs_ff[rx_addr];

  // [R17] write lands at once; no store delay is modelled
  integer i;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < NREGS; i = i + 1) begin
        regs_ff[i] <= `ASSPI_REG_RESET;
      end
    end else if (state_ff == ST_FRAME && sclk_rise &&
                 bit_cnt_ff == `ASSPI_FRAME_BITS - 1 && rx_cmd == `ASSPI_CMD_WRITE) begin
      regs_ff[rx_addr] <= rx_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      sclk_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
      ref_cnt_ff <= 7'h00;
      angle_buf_ff <= 16'h0000;
      shift_ff <= 16'h0000;
      rx_ff <= 16'h0000;
      tx_word_ff <= 16'h0000;
      bit_cnt_ff <= 5'h00;
      pend_ff <= 1'b0;
      pend_word_ff <= 16'h0000;
      miso_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
      wr_pulse_ff <= 1'b0;
      wr_addr_ff <= 5'h00;
      wr_data_ff <= 8'h00;
    end else begin
      sclk_d_ff <= sclk_s;
      cs_d_ff <= cs_n_s;
      // write strobe lasts one clock
      wr_pulse_ff <= 1'b0;
      // [R7] periodic refresh
      ref_cnt_ff <= (ref_cnt_ff == REFRESH_LAST) ? 7'h00 : ref_cnt_ff + 7'h01;
      // [R12] same word until reload
      // [R8] frozen while selected
      if (ref_cnt_ff == REFRESH_LAST && state_ff == ST_IDLE && !cs_fall) begin
        angle_buf_ff <= angle_pad;
      end
      case (state_ff)
        ST_IDLE: begin
          miso_oe_ff <= 1'b0;
          miso_ff <= 1'b0;
          if (cs_fall) begin
            // [R9] buffered word sent
            // [R16] pending reply or [R22] angle
            shift_ff <= pend_ff ? pend_word_ff : angle_buf_ff;
            tx_word_ff <= pend_ff ? pend_word_ff : angle_buf_ff;
            // [R4] msb first, valid before first edge
            miso_ff <= pend_ff ? pend_word_ff[15] : angle_buf_ff[15];
            miso_oe_ff <= 1'b1;
            pend_ff <= 1'b0;
            bit_cnt_ff <= 5'h00;
            state_ff <= ST_FRAME;
          end
        end
        ST_FRAME: begin
          // a cs edge seen with an sclk edge: cs wins and the frame ends
          if (cs_rise) begin
            // [R8] release on deselect
            state_ff <= ST_IDLE;
            miso_oe_ff <= 1'b0;
          end else begin
            // sclk needs at least 4 clocks per level; faster links are missed
            // [R1] same edges serve mode 0 and mode 3
            if (sclk_rise) begin
              // [R4] sample mosi on rising edge
              rx_ff <= rx_full;
              if (bit_cnt_ff != 5'h1F) begin
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
              end
              if (bit_cnt_ff == `ASSPI_FRAME_BITS - 1) begin
                // [R13] decode the command word
                if (rx_cmd == `ASSPI_CMD_READ) begin
                  // [R14] register read request
                  pend_ff <= 1'b1;
                  pend_word_ff <= {rd_val, 8'h00};
                end else if (rx_cmd == `ASSPI_CMD_WRITE) begin
                  // [R17] store and echo next frame
                  pend_ff <= 1'b1;
                  pend_word_ff <= {rx_data, 8'h00};
                  wr_pulse_ff <= 1'b1;
                  wr_addr_ff <= rx_addr;
                  wr_data_ff <= rx_data;
                end
              end
            end
            // [R4] mode 3 first falling edge is idle-to-active, not a shift
            if (sclk_fall && bit_cnt_ff != 5'h00) begin
              if (bit_cnt_ff < `ASSPI_FRAME_BITS) begin
                shift_ff <= {shift_ff[14:0], 1'b0};
                miso_ff <= shift_ff[14];
              end else if (bit_cnt_ff == `ASSPI_FRAME_BITS) begin
                // [R5] [R6] even parity after 16 bits
                miso_ff <= parity_even(tx_word_ff);
              end else begin
                // clocks past the parity bit read as zero
                miso_ff <= 1'b0;
              end
            end
          end
        end
        // illegal state codes fall back to idle
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* test/asspi_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module asspi_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // spi pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic miso_ff,
  input wire logic miso_oe_ff,
  // write strobe side
  input wire logic wr_pulse_ff,
  input wire logic [4:0] wr_addr_ff,
  input wire logic [7:0] wr_data_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  oe_idle_a: assert property (cs_n [*6] |-> !miso_oe_ff)
    else $error("oe high while idle");
  oe_sel_a: assert property (!cs_n [*6] |-> miso_oe_ff)
    else $error("oe low while selected");
  oe_rise_a: assert property ($fell(cs_n) |-> ##[1:5] miso_oe_ff)
    else $error("oe late");
  oe_drop_a: assert property ($rose(cs_n) |-> ##[1:5] !miso_oe_ff)
    else $error("oe held");
  // pins settle within 5 cycles, so 7 quiet samples leave miso still
  miso_still_a: assert property (($stable(sclk) && $stable(cs_n)) [*7] |-> $stable(miso_ff))
    else $error("miso moved without edge");
  wr_single_a: assert property (wr_pulse_ff |=> !wr_pulse_ff [*8])
    else $error("write pulse repeated");
  wr_hold_a: assert property (!wr_pulse_ff |-> $stable(wr_addr_ff) && $stable(wr_data_ff))
    else $error("write fields moved");
  wr_frame_a: assert property (wr_pulse_ff |-> !$past(cs_n, 6))
    else $error("write outside frame");
endmodule
bind asspi_slave asspi_monitor i_asspi_monitor (.*);
`default_nettype wire

/* test/asspi_master.sv */
`timescale 1ns/1ns
`default_nettype none
// sclk steps to its mode's idle level before cs falls and again before cs rises; mosi rests low like its pull-down
module asspi_master (
  // bench clock
  input wire logic clk,
  // spi pins
  output var logic cs_n = 1'b1,
  output var logic sclk = 1'b0,
  output var logic mosi = 1'b0,
  input wire logic miso
);
  // 8 clocks per sclk period (64 ns), msb first, driven on the clock edge
  // 16-bit frames, mosi zero for angles, 800 ns idle after each
  task automatic xfer(input logic [15:0] tx, input logic m3, input int n,
                      output logic [16:0] rx);
    rx = 17'h00000;
    @(posedge clk) sclk <= m3;
    repeat (2) @(posedge clk);
    cs_n <= 1'b0;
    repeat (10) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b0;
      mosi <= (i < 16) ? tx[15 - i] : 1'b0;
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      rx = {rx[15:0], miso};
      repeat (4) @(posedge clk);
    end
    sclk <= m3;
    mosi <= 1'b0;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    repeat (100) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* test/asspi_slave_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module asspi_slave_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] angle_in = 12'h000;
  logic field_high_flag = 1'b0;
  logic field_low_flag = 1'b0;
  wire logic cs_n, sclk, mosi, miso_ff, miso_oe_ff, wr_pulse_ff;
  wire logic [4:0] wr_addr_ff;
  wire logic [7:0] wr_data_ff;
  wire logic miso_pin = miso_oe_ff ? miso_ff : 1'b0;
  logic [16:0] rx;
  int failures = 0, check_count = 0, cycles = 0, wr_seen = 0;
  initial forever #4 clk = ~clk;
  asspi_slave i_asspi_slave (
    .clk(clk),
    .rst(rst),
    .cs_n(cs_n),
    .sclk(sclk),
    .mosi(mosi),
    .miso_ff(miso_ff),
    .miso_oe_ff(miso_oe_ff),
    .angle_in(angle_in),
    .field_high_flag(field_high_flag),
    .field_low_flag(field_low_flag),
    .wr_pulse_ff(wr_pulse_ff),
    .wr_addr_ff(wr_addr_ff),
    .wr_data_ff(wr_data_ff)
  );
  asspi_master i_asspi_master (
    .clk(clk),
    .cs_n(cs_n),
    .sclk(sclk),
    .mosi(mosi),
    .miso(miso_pin)
  );
  task automatic report_and_stop;
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [16:0] exp, got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wr_pulse_ff === 1'b1) wr_seen <= wr_seen + 1;
    // nine frames need about 2640 cycles
    if (cycles == 20000) begin
      failures++;
      report_and_stop;
    end
  end
  task automatic t_angle(input logic [11:0] a, input logic m3);
    @(posedge clk) angle_in <= a;
    repeat (140) @(posedge clk);
    i_asspi_master.xfer(16'h0000, m3, 17, rx);
    chk("angle", {a, 4'h0, ^a}, rx);
  endtask
  task automatic t_freeze;
    fork
      i_asspi_master.xfer(16'h0000, 1'b0, 16, rx);
      begin
        // the frame outlasts this change by more than one refresh period
        repeat (8) @(posedge clk);
        angle_in <= 12'h3A5;
      end
    join
    chk("frozen", 17'h05D00, rx);
    repeat (140) @(posedge clk);
    i_asspi_master.xfer(16'h0000, 1'b1, 12, rx);
    chk("short", 17'h003A5, rx);
  endtask
  task automatic t_regs;
    int n0;
    n0 = wr_seen;
    // the design stores at once, so nvm_update_wait shrinks to the idle gap
    i_asspi_master.xfer(16'h853C, 1'b0, 16, rx);
    i_asspi_master.xfer(16'h4500, 1'b1, 16, rx);
    chk("echo", 17'h03C00, rx);
    chk("wr_addr", 17'h00005, {12'h000, wr_addr_ff});
    chk("wr_data", 17'h0003C, {9'h000, wr_data_ff});
    chk("wr_count", 17'h00001, 17'(wr_seen - n0));
    i_asspi_master.xfer(16'h0000, 1'b0, 17, rx);
    chk("reg5", 17'h07800, rx);
    @(posedge clk) field_high_flag <= 1'b1;
    i_asspi_master.xfer(16'h5B00, 1'b0, 17, rx);
    chk("first", {12'h3A5, 4'h0, ^12'h3A5}, rx);
    i_asspi_master.xfer(16'h0000, 1'b1, 16, rx);
    chk("flags", 17'h08000, rx);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_angle(12'hABC, 1'b0);
    t_angle(12'h5D0, 1'b1);
    t_freeze;
    t_regs;
    report_and_stop;
  end
endmodule
`default_nettype wire
